/* verilog/adc_scan_params.svh */
`ifndef ADC_SCAN_PARAMS_SVH
`define ADC_SCAN_PARAMS_SVH

// Byte address width of the register bus and number of scan channels.
`define ADC_ADDR_W 18
`define ADC_NUM_CHAN 12

// Register indexes; the byte address of a register is four times its index.
`define ADC_IDX_RESULT_BASE 16'hf8d0
`define ADC_IDX_TIMING 16'hf8f0
`define ADC_IDX_CONTROL 16'hf8f1
`define ADC_IDX_SEL_LOW 16'hf8f2
`define ADC_IDX_SEL_HIGH 16'hf8f3
`define ADC_IDX_IRQ_STATUS 16'hf8f4
`define ADC_IDX_IRQ_MASK 16'hf8f5

// Field positions.
`define ADC_RUN_BIT 0
`define ADC_LOOP_BIT 0
`define ADC_SLOW_BIT 1
`define ADC_IRQ_DONE_BIT 0
`define ADC_IRQ_REFUSED_BIT 1
`define ADC_IRQ_BITS 2

// Reset value of every register of the block.
`define ADC_REG_RESET 8'h00

`endif

/* verilog/adc_scan_pkg.sv */
package adc_scan_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_WAIT = 2'b10
	} scan_state_e;

	// Request towards the analog converter.
	typedef struct packed {
		logic start;
		logic abort;
		logic slow;
		logic [3:0] channel;
	} conv_req_s;

	// Answer from the analog converter.
	typedef struct packed {
		logic done;
		logic [9:0] result;
	} conv_rsp_s;

endpackage

/* verilog/adc_next_channel.sv */
`timescale 1ns/100ps
`default_nettype none

// Finds the lowest enabled channel, either from channel 0 upward or strictly
// above a given channel.
module adc_next_channel #(
	parameter int NCH = 12
) (
	input wire logic [NCH-1:0] mask,
	input wire logic [3:0] after_chan,
	input wire logic from_start,
	output logic found,
	output logic [3:0] chan
);

	always_comb begin
		found = 1'b0;
		chan = 4'h0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (mask[i] && (from_start || i > int'(after_chan))) begin
				found = 1'b1;
				chan = 4'(i);
			end
		end
	end

endmodule

`default_nettype wire

/* verilog/adc_irq_status.sv */
`timescale 1ns/100ps
`default_nettype none

// Sticky event flags, cleared by writing a one, gated by a mask onto one
// level interrupt.
module adc_irq_status #(
	parameter int N = 2
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [N-1:0] event_set,
	input wire logic [N-1:0] status_clr,
	input wire logic mask_wr,
	input wire logic [N-1:0] mask_wdata,
	output logic [N-1:0] status_q,
	output logic [N-1:0] mask_q,
	output logic irq
);

	// A flag raised in the cycle it is cleared stays set.
	always_ff @(posedge clock) begin
		if (rst) begin
			status_q <= '0;
		end else begin
			status_q <= (status_q & ~status_clr) | event_set;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			mask_q <= '0;
		end else if (mask_wr) begin
			mask_q <= mask_wdata;
		end
	end

	assign irq = |(status_q & mask_q);

endmodule

`default_nettype wire

/* verilog/adc_channel_scan_control.sv */
`timescale 1ns/100ps
`default_nettype none
`include "adc_scan_params.svh"

// Summary of operation
// - Run bit one starts scan, zero stops.
// - Single mode clears run after last channel.
// - Start with no channel enabled is ignored.
// - Low select register enables channels 0-7.
// - High select enables channels 8-11; rest zero.
// - Channels convert lowest number first, ascending.
// - Control resets to zero; upper bits zero.
// - Both select registers reset to zero.
// - Loop mode restarts scan after last channel while any channel is enabled.
// - Last channel completion raises scan done event.
// - Selection captured at start held until done.
// - Results split high eight, low two bits.
module adc_channel_scan_control
	import adc_scan_pkg::*;
#(
	parameter int ADDR_W = `ADC_ADDR_W
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output conv_req_s conv_req,
	input wire conv_rsp_s conv_rsp,
	output logic scan_done_irq
);

	localparam int NCH = `ADC_NUM_CHAN;
	localparam logic [15:0] RES_BASE = `ADC_IDX_RESULT_BASE;
	localparam logic [15:0] RES_END = RES_BASE + 16'(2 * NCH);

	logic [15:0] idx;
	logic [7:0] wd;
	logic wr_byte;
	logic wr_timing;
	logic wr_ctrl;
	logic wr_sel_low;
	logic wr_sel_high;
	logic wr_irq_status;
	logic wr_irq_mask;

	logic loop_select_q;
	logic slow_timing_q;
	logic scan_run_q;
	logic [7:0] sel_low_q;
	logic [3:0] sel_high_q;
	logic [NCH-1:0] live_mask;
	logic [NCH-1:0] scan_mask_q;
	logic [3:0] cur_chan_q;
	scan_state_e state_q;
	logic abort_q;
	logic [9:0] results_q [NCH];

	logic first_found;
	logic [3:0] first_chan;
	logic next_found;
	logic [3:0] next_chan;

	logic conv_ok;
	logic scan_end;
	logic start_req;
	logic stop_req;
	logic refused;
	logic restart;

	logic [`ADC_IRQ_BITS-1:0] irq_events;
	logic [`ADC_IRQ_BITS-1:0] irq_clr;
	logic [`ADC_IRQ_BITS-1:0] irq_status_q;
	logic [`ADC_IRQ_BITS-1:0] irq_mask_q;

	logic rd_valid_q;
	logic [31:0] readdata_q;
	logic [7:0] rd_byte;
	logic [15:0] res_off;
	logic [9:0] res_word;

	// Bus decode: data lives in byte lane 0 of each word.
	assign idx = 16'(address[ADDR_W-1:2]);
	assign wd = writedata[7:0];
	assign wr_byte = write && byteenable[0];
	assign wr_timing = wr_byte && (idx == `ADC_IDX_TIMING);
	assign wr_ctrl = wr_byte && (idx == `ADC_IDX_CONTROL);
	assign wr_sel_low = wr_byte && (idx == `ADC_IDX_SEL_LOW);
	assign wr_sel_high = wr_byte && (idx == `ADC_IDX_SEL_HIGH);
	assign wr_irq_status = wr_byte && (idx == `ADC_IDX_IRQ_STATUS);
	assign wr_irq_mask = wr_byte && (idx == `ADC_IDX_IRQ_MASK);

	always_ff @(posedge clock) begin
		if (rst) begin
			loop_select_q <= 1'b0;
			slow_timing_q <= 1'b0;
		end else if (wr_timing) begin
			loop_select_q <= wd[`ADC_LOOP_BIT];
			slow_timing_q <= wd[`ADC_SLOW_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			sel_low_q <= `ADC_REG_RESET;
			sel_high_q <= 4'h0;
		end else begin
			if (wr_sel_low) begin
				sel_low_q <= wd;
			end
			if (wr_sel_high) begin
				sel_high_q <= wd[3:0];
			end
		end
	end

	assign live_mask = {sel_high_q, sel_low_q};

	adc_next_channel #(.NCH(NCH)) u_first (
		.mask(live_mask),
		.after_chan(4'h0),
		.from_start(1'b1),
		.found(first_found),
		.chan(first_chan)
	);

	adc_next_channel #(.NCH(NCH)) u_next (
		.mask(scan_mask_q),
		.after_chan(cur_chan_q),
		.from_start(1'b0),
		.found(next_found),
		.chan(next_chan)
	);

	assign conv_ok = conv_rsp.done && (state_q == ST_WAIT);
	assign scan_end = conv_ok && !next_found;
	assign start_req = wr_ctrl && wd[`ADC_RUN_BIT] && !scan_run_q;
	assign stop_req = wr_ctrl && !wd[`ADC_RUN_BIT];
	assign refused = start_req && !first_found;
	assign restart = scan_end && loop_select_q && first_found && !stop_req;

	// Scan sequencer. A stop write wins over a completion in the same cycle.
	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= ST_IDLE;
			scan_run_q <= 1'b0;
			scan_mask_q <= '0;
			cur_chan_q <= 4'h0;
			abort_q <= 1'b0;
		end else begin
			abort_q <= stop_req && (state_q != ST_IDLE);
			if (stop_req) begin
				scan_run_q <= 1'b0;
				state_q <= ST_IDLE;
			end else if (start_req && first_found) begin
				scan_run_q <= 1'b1;
				scan_mask_q <= live_mask;
				cur_chan_q <= first_chan;
				state_q <= ST_START;
			end else begin
				case (state_q)
					ST_IDLE: begin
						state_q <= ST_IDLE;
					end
					ST_START: begin
						state_q <= ST_WAIT;
					end
					ST_WAIT: begin
						if (conv_ok && next_found) begin
							cur_chan_q <= next_chan;
							state_q <= ST_START;
						end else if (restart) begin
							scan_mask_q <= live_mask;
							cur_chan_q <= first_chan;
							state_q <= ST_START;
						end else if (conv_ok) begin
							scan_run_q <= 1'b0;
							state_q <= ST_IDLE;
						end
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// Only a completed conversion writes its own channel's result.
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < NCH; i++) begin
				results_q[i] <= 10'h000;
			end
		end else if (conv_ok) begin
			results_q[cur_chan_q] <= conv_rsp.result;
		end
	end

	assign conv_req.start = (state_q == ST_START);
	assign conv_req.abort = abort_q;
	assign conv_req.slow = slow_timing_q;
	assign conv_req.channel = cur_chan_q;

	assign irq_events[`ADC_IRQ_DONE_BIT] = scan_end;
	assign irq_events[`ADC_IRQ_REFUSED_BIT] = refused;
	assign irq_clr = wr_irq_status ? wd[`ADC_IRQ_BITS-1:0] : '0;

	adc_irq_status #(.N(`ADC_IRQ_BITS)) u_irq (
		.clock(clock),
		.rst(rst),
		.event_set(irq_events),
		.status_clr(irq_clr),
		.mask_wr(wr_irq_mask),
		.mask_wdata(wd[`ADC_IRQ_BITS-1:0]),
		.status_q(irq_status_q),
		.mask_q(irq_mask_q),
		.irq(scan_done_irq)
	);

	// Read mux; unmapped indexes and reserved bits read as zero.
	always_comb begin
		rd_byte = 8'h00;
		res_off = idx - RES_BASE;
		res_word = results_q[res_off[4:1]];
		if (idx >= RES_BASE && idx < RES_END) begin
			rd_byte = res_off[0] ? res_word[9:2] : {res_word[1:0], 6'h00};
		end else begin
			case (idx)
				`ADC_IDX_TIMING: rd_byte = {6'h00, slow_timing_q, loop_select_q};
				`ADC_IDX_CONTROL: rd_byte = {7'h00, scan_run_q};
				`ADC_IDX_SEL_LOW: rd_byte = sel_low_q;
				`ADC_IDX_SEL_HIGH: rd_byte = {4'h0, sel_high_q};
				`ADC_IDX_IRQ_STATUS: rd_byte = {6'h00, irq_status_q};
				`ADC_IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask_q};
				default: rd_byte = 8'h00;
			endcase
		end
	end

	// Reads take one wait cycle so that read data come from a flip-flop.
	always_ff @(posedge clock) begin
		if (rst) begin
			rd_valid_q <= 1'b0;
			readdata_q <= 32'h0000_0000;
		end else begin
			rd_valid_q <= read && !rd_valid_q;
			if (read && !rd_valid_q) begin
				readdata_q <= {24'h00_0000, rd_byte};
			end
		end
	end

	assign readdata = readdata_q;
	assign waitrequest = read && !rd_valid_q;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	a_start_takes: assert property (start_req && first_found && !stop_req
		|=> scan_run_q && state_q == ST_START && conv_req.start)
		else $error("scan did not start on run write");

	a_stop_clears: assert property (stop_req
		|=> !scan_run_q && state_q == ST_IDLE
		##1 (conv_req.start == $past(start_req && first_found)))
		else $error("run clear did not stop the scan");

	a_single_end: assert property (scan_end && !loop_select_q && !stop_req
		|=> !scan_run_q && state_q == ST_IDLE)
		else $error("single scan left run bit set");

	a_empty_refused: assert property (refused
		|=> !scan_run_q ##1 (scan_run_q == $past(start_req && first_found)))
		else $error("start with no channels was not ignored");

	a_reserved_zero: assert property (rd_valid_q |-> readdata[31:8] == 24'h00_0000
		&& ($past(idx) != `ADC_IDX_SEL_HIGH || readdata[7:4] == 4'h0))
		else $error("reserved bits read non-zero");

	a_order_up: assert property (conv_ok && next_found && !stop_req
		|=> cur_chan_q > $past(cur_chan_q) && scan_mask_q[cur_chan_q])
		else $error("channels not converted in ascending order");

	a_reset_values: assert property ($past(rst) |-> !scan_run_q
		&& sel_low_q == 8'h00 && sel_high_q == 4'h0 && state_q == ST_IDLE)
		else $error("registers not at reset value");

	a_loop_restart: assert property (restart
		|=> scan_run_q && state_q == ST_START && cur_chan_q == $past(first_chan))
		else $error("loop mode did not restart the scan");

	a_done_flag: assert property (scan_end
		|=> irq_status_q[`ADC_IRQ_DONE_BIT])
		else $error("scan end did not set the done flag");

	a_mask_held: assert property (state_q == ST_WAIT && !conv_rsp.done
		|=> $stable(scan_mask_q))
		else $error("captured selection changed during conversion");

	a_result_store: assert property (conv_ok
		|=> results_q[$past(cur_chan_q)] == $past(conv_rsp.result))
		else $error("result not stored for converted channel");

	c_single_scan: cover property (scan_end && !loop_select_q ##1 !scan_run_q);
	c_loop_scan: cover property (restart);
	c_refused: cover property (refused);
	c_abort: cover property (stop_req && state_q == ST_WAIT);

endmodule

`default_nettype wire

/* tb/test_adc_channel_scan_control.sv */
`timescale 1ns/100ps
`default_nettype none
`include "adc_scan_params.svh"

module test_adc_channel_scan_control
	import adc_scan_pkg::*;
();
	localparam int LIMIT = 20000;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [17:0] address = 18'h00000;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h00000000;
	logic [3:0] byteenable = 4'h1;
	logic [31:0] readdata;
	logic waitrequest;
	conv_req_s conv_req;
	conv_rsp_s conv_rsp = '0;
	logic scan_done_irq;
	int fails = 0;
	int tests_run = 0;
	int cycles = 0;

	always #5 clock = ~clock;

	adc_channel_scan_control u_adc_channel_scan_control (
		.clock(clock),
		.rst(rst),
		.address(address),
		.read(read),
		.write(write),
		.writedata(writedata),
		.byteenable(byteenable),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.conv_req(conv_req),
		.conv_rsp(conv_rsp),
		.scan_done_irq(scan_done_irq)
	);

	task automatic wrap_up();
		$display("tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == LIMIT) begin
			fails++;
			wrap_up();
		end
	end

	task automatic chk_reg(string name, logic [7:0] exp, logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic chk_bit(string name, logic exp, logic got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %b, seen %b", name, exp, got);
		end
	endtask

	// Requests are held until the edge that samples waitrequest low.
	task automatic bus_write(logic [15:0] idx, logic [7:0] data, logic [3:0] be = 4'h1);
		@(posedge clock);
		address <= {idx, 2'b00};
		writedata <= {24'h000000, data};
		byteenable <= be;
		write <= 1'b1;
		do @(posedge clock); while (waitrequest !== 1'b0);
		write <= 1'b0;
	endtask

	task automatic rd_chk(logic [15:0] idx, logic [7:0] exp);
		logic [7:0] got;
		@(posedge clock);
		address <= {idx, 2'b00};
		read <= 1'b1;
		do @(posedge clock); while (waitrequest !== 1'b0);
		got = readdata[7:0];
		read <= 1'b0;
		chk_reg($sformatf("reg %h", idx), exp, got);
	endtask

	task automatic chk_result(logic [3:0] ch, logic [9:0] r);
		rd_chk(`ADC_IDX_RESULT_BASE + 16'(2 * ch), {r[1:0], 6'h00});
		rd_chk(`ADC_IDX_RESULT_BASE + 16'(2 * ch) + 16'h0001, r[9:2]);
	endtask

	task automatic wait_start(logic [3:0] ch);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (conv_req.start !== 1'b1 && n < 50);
		chk_bit("start", 1'b1, conv_req.start);
		chk_reg("channel", {4'h0, ch}, {4'h0, conv_req.channel});
	endtask

	// The result lines carry the inverse once done is released.
	task automatic give_done(logic [9:0] r);
		@(posedge clock);
		conv_rsp <= '{done: 1'b1, result: r};
		@(posedge clock);
		conv_rsp <= '{done: 1'b0, result: ~r};
	endtask

	initial begin
		int n;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		chk_bit("irq", 1'b0, scan_done_irq);
		chk_bit("slow", 1'b0, conv_req.slow);
		rd_chk(`ADC_IDX_CONTROL, 8'h00);
		rd_chk(`ADC_IDX_SEL_LOW, 8'h00);
		rd_chk(`ADC_IDX_SEL_HIGH, 8'h00);
		rd_chk(16'h0100, 8'h00);
		bus_write(`ADC_IDX_SEL_HIGH, 8'hff);
		rd_chk(`ADC_IDX_SEL_HIGH, 8'h0f);
		bus_write(`ADC_IDX_SEL_HIGH, 8'h00);
		bus_write(`ADC_IDX_SEL_LOW, 8'h5a, 4'h0);
		rd_chk(`ADC_IDX_SEL_LOW, 8'h00);
		bus_write(`ADC_IDX_CONTROL, 8'h01);
		rd_chk(`ADC_IDX_CONTROL, 8'h00);
		rd_chk(`ADC_IDX_IRQ_STATUS, 8'h02);
		chk_bit("irq", 1'b0, scan_done_irq);
		bus_write(`ADC_IDX_IRQ_MASK, 8'h03);
		@(negedge clock);
		chk_bit("irq", 1'b1, scan_done_irq);
		bus_write(`ADC_IDX_IRQ_STATUS, 8'h02);
		@(negedge clock);
		chk_bit("irq", 1'b0, scan_done_irq);
		// Single scan of channels 0, 7 and 11; low select cleared mid-scan.
		bus_write(`ADC_IDX_SEL_LOW, 8'h81);
		bus_write(`ADC_IDX_SEL_HIGH, 8'h08);
		bus_write(`ADC_IDX_CONTROL, 8'hff);
		wait_start(4'd0);
		rd_chk(`ADC_IDX_CONTROL, 8'h01);
		bus_write(`ADC_IDX_SEL_LOW, 8'h00);
		give_done(10'h2c7);
		wait_start(4'd7);
		give_done(10'h135);
		wait_start(4'd11);
		give_done(10'h3fa);
		@(negedge clock);
		chk_bit("irq", 1'b1, scan_done_irq);
		rd_chk(`ADC_IDX_CONTROL, 8'h00);
		rd_chk(`ADC_IDX_IRQ_STATUS, 8'h01);
		chk_result(4'd0, 10'h2c7);
		chk_result(4'd7, 10'h135);
		chk_result(4'd11, 10'h3fa);
		bus_write(`ADC_IDX_IRQ_STATUS, 8'h01);
		@(negedge clock);
		chk_bit("irq", 1'b0, scan_done_irq);
		// Loop mode on channel 1, then a stop while converting.
		bus_write(`ADC_IDX_SEL_LOW, 8'h02);
		bus_write(`ADC_IDX_SEL_HIGH, 8'h00);
		bus_write(`ADC_IDX_TIMING, 8'h03);
		rd_chk(`ADC_IDX_TIMING, 8'h03);
		chk_bit("slow", 1'b1, conv_req.slow);
		bus_write(`ADC_IDX_CONTROL, 8'h01);
		wait_start(4'd1);
		give_done(10'h1e5);
		wait_start(4'd1);
		bus_write(`ADC_IDX_CONTROL, 8'h00);
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (conv_req.abort !== 1'b1 && n < 4);
		chk_bit("abort", 1'b1, conv_req.abort);
		give_done(10'h00f);
		rd_chk(`ADC_IDX_CONTROL, 8'h00);
		chk_result(4'd1, 10'h1e5);
		wrap_up();
	end
endmodule
`default_nettype wire
